/* File: cpu_operand_addressing_flags_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_operand_addressing_flags_tb_top;
  reg mclk, rstn, start;
  reg [2:0] op;
  reg [3:0] mode;
  reg [7:0] byte1, byte2;
  reg [15:0] next_pc;
  wire [7:0] mem_hi, mem_lo, acc, flags;
  wire [15:0] ea, ea_plus1, word_data, branch_target, index_pair, stack_ptr;
  wire mode_ok, done, bad_mode;
  integer fail_count = 0, tests_run = 0, cyc = 0;
  oad_core dut (.mclk, .rstn, .start, .op, .mode, .byte1, .byte2, .next_pc, .mem_hi, .mem_lo,
    .ea, .ea_plus1, .mode_ok, .word_data, .branch_target, .acc, .index_pair, .stack_ptr,
    .condition_flag_register(flags), .done, .bad_mode);
  oad_mem mem (.ea, .ea_plus1, .mem_hi, .mem_lo);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      finish_test;
    end
  end
  function [7:0] mb(input [15:0] a);
    mb = a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task issue(input [2:0] o, input [3:0] m, input [7:0] b1, input [7:0] b2, input [15:0] e,
    input r);
    integer i;
    begin
      @(negedge mclk);
      op = o;
      mode = m;
      byte1 = b1;
      byte2 = b2;
      start = 1'b1;
      #1 if (m != 4'h0 && m != 4'ha) chk(ea, e);
      @(negedge mclk);
      start = 1'b0;
      for (i = 0; i < 4 && !(done || bad_mode); i = i + 1) @(negedge mclk);
      chk({done, bad_mode}, r ? 2'b01 : 2'b10);
    end
  endtask
  task t_add;
    begin
      chk({flags, stack_ptr}, 24'h0800ff);
      issue(3'h2, 4'h0, 8'h7f, 8'h00, 16'h0, 0);
      issue(3'h2, 4'h0, 8'h01, 8'h00, 16'h0, 0);
      chk({acc, flags}, 16'h809c);
      issue(3'h2, 4'h0, 8'h80, 8'h00, 16'h0, 0);
      chk({acc, flags}, 16'h008b);
      issue(3'h1, 4'h0, 8'h01, 8'h00, 16'h0, 0);
      chk({acc, flags}, 16'h0208);
      issue(3'h2, 4'h2, 8'h12, 8'h34, 16'h1234, 0);
      chk(word_data, {mb(16'h1234), mb(16'h1235)});
      chk({acc, flags}, 16'h7e08);
      $display("add test done");
    end
  endtask
  task t_addr;
    begin
      issue(3'h4, 4'h6, 8'h00, 8'h00, 16'h0000, 0);
      chk(index_pair, 16'h0001);
      issue(3'h4, 4'h4, 8'hff, 8'h00, 16'h0100, 0);
      issue(3'h4, 4'h5, 8'hff, 8'hff, 16'h0000, 0);
      issue(3'h6, 4'h1, 8'hab, 8'h00, 16'h00ab, 0);
      issue(3'h3, 4'h0, 8'hfe, 8'h00, 16'h0, 0);
      chk({stack_ptr, flags}, {16'h00fd, 8'h08});
      issue(3'h6, 4'h9, 8'h01, 8'h00, 16'h01fd, 0);
      issue(3'h6, 4'h8, 8'h03, 8'h00, 16'h0100, 0);
      issue(3'h4, 4'ha, 8'h80, 8'h00, 16'h0, 0);
      chk(branch_target, 16'hff90);
      issue(3'h4, 4'ha, 8'h7f, 8'h00, 16'h0, 0);
      chk(branch_target, 16'h008f);
      $display("address test done");
    end
  endtask
  task t_refuse;
    begin
      issue(3'h1, 4'h6, 8'h00, 8'h00, 16'h0001, 1);
      issue(3'h5, 4'h7, 8'h00, 8'h00, 16'h0001, 1);
      chk({acc, index_pair}, {mb(16'h0100), 16'h0001});
      issue(3'h5, 4'h6, 8'h00, 8'h00, 16'h0001, 0);
      chk(index_pair, 16'h0002);
      $display("refuse test done");
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    {rstn, start, op, mode, byte1, byte2} = 0;
    next_pc = 16'h0010;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    t_add;
    t_addr;
    t_refuse;
    finish_test;
  end
endmodule // cpu_operand_addressing_flags_tb_top
`default_nettype wire

/* File: oad_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module oad_checker (
  input wire mclk, input wire rstn, input wire start, input wire [2:0] op,
  input wire [3:0] mode, input wire [7:0] byte1, input wire [7:0] byte2,
  input wire [7:0] mem_hi, input wire [7:0] mem_lo, input wire [15:0] ea,
  input wire [15:0] ea_plus1, input wire mode_ok, input wire [15:0] word_data,
  input wire [15:0] index_pair, input wire [7:0] condition_flag_register, input wire done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire go = start && mode_ok;
  flag_pad_a: assert property (condition_flag_register[6:5] == 2'h0) else $error("pad");
  low_byte_a: assert property (ea_plus1 == ea + 16'h0001) else $error("ea+1");
  direct_ea_a: assert property (start && mode == 4'h1 |-> ea == {8'h00, byte1})
    else $error("direct");
  full_ea_a: assert property (start && mode == 4'h2 |-> ea == {byte1, byte2})
    else $error("full");
  ix_long_a: assert property (start && mode == 4'h5 |-> ea == index_pair + {byte1, byte2})
    else $error("ix long");
  word_join_a: assert property (done |-> word_data == {$past(mem_hi), $past(mem_lo)})
    else $error("word");
  adjust_keep_a: assert property (go && op == 3'h3 |=> $stable(condition_flag_register)[*2])
    else $error("adjust");
  post_inc_a: assert property (go && mode == 4'h6 |-> ##2 index_pair == $past(index_pair, 2) + 16'h0001)
    else $error("postinc");
  cover property (go && op == 3'h1);
  cover property (go && op == 3'h3);
  cover property (go && mode == 4'ha);
endmodule // oad_checker
bind oad_core oad_checker u_chk (.mclk, .rstn, .start, .op, .mode, .byte1, .byte2, .mem_hi,
  .mem_lo, .ea, .ea_plus1, .mode_ok, .word_data, .index_pair, .condition_flag_register, .done);
`default_nettype wire

/* File: oad_core.v */
`timescale 1ns/100ps
`default_nettype none
`include "oad_regs.vh"

module oad_core (
  input wire mclk, // 10 MHz clock
  input wire rstn, // async reset, active low
  input wire start, // one-cycle pulse: execute the presented instruction
  input wire [2:0] op, // operation code
  input wire [3:0] mode, // addressing mode
  input wire [7:0] byte1, // first operand byte of the instruction
  input wire [7:0] byte2, // second operand byte of the instruction
  input wire [15:0] next_pc, // address after the last instruction byte
  input wire [7:0] mem_hi, // byte read at the operand address
  input wire [7:0] mem_lo, // byte read at operand address plus one
  output wire [15:0] ea, // effective address, combinational
  output wire [15:0] ea_plus1, // address of the low byte of a 16-bit value
  output wire mode_ok, // mode legal for the op, combinational
  output reg [15:0] word_data, // last 16-bit value assembled from memory
  output reg [15:0] branch_target, // last computed branch target
  output reg [7:0] acc, // accumulator
  output reg [15:0] index_pair, // index pair, high:low
  output reg [15:0] stack_ptr, // stack pointer
  output reg [7:0] condition_flag_register, // V 0 0 H I N Z C
  output reg done, // one-cycle pulse after an accepted start
  output reg bad_mode // one-cycle pulse after a refused start
);

  // ****************************************
  // states, one-hot
  // ****************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;

  // latched request so inputs may change after start; the second
  // operand byte only feeds ea, which is formed from the live inputs
  reg [2:0] op_q;
  reg [3:0] mode_q;
  reg [7:0] b1_q;
  reg [15:0] pc_q;

  // next values of the architectural registers
  reg [7:0] next_acc;
  reg [7:0] next_flags;
  reg [15:0] next_index;
  reg [15:0] next_sp;
  reg [15:0] next_word;
  reg [15:0] next_target;
  reg next_done;
  reg next_bad_mode;

  // ****************************************
  // address formation
  // ****************************************
  function [15:0] calc_ea;
    input [3:0] m;
    input [7:0] a;
    input [7:0] b;
    input [15:0] hx;
    input [15:0] sp;
    begin
      case (m)
        `OAD_MODE_DIRECT: calc_ea = {8'h00, a};
        `OAD_MODE_FULL: calc_ea = {a, b};
        `OAD_MODE_INDEX, `OAD_MODE_IX_POSTINC: calc_ea = hx;
        `OAD_MODE_IX_SHORT, `OAD_MODE_IX_OFS_POSTINC: calc_ea = hx + {8'h00, a};
        `OAD_MODE_IX_LONG: calc_ea = hx + {a, b};
        `OAD_MODE_SP_SHORT: calc_ea = sp + {8'h00, a};
        `OAD_MODE_SP_LONG: calc_ea = sp + {a, b};
        default: calc_ea = 16'h0000;
      endcase
    end
  endfunction

  // legality of a mode for an operation
  function legal;
    input [2:0] o;
    input [3:0] m;
    begin
      case (m)
        `OAD_MODE_IX_POSTINC:
          legal = (o == `OAD_OP_COMPARE_BRANCH) || (o == `OAD_OP_MOVE);
        `OAD_MODE_IX_OFS_POSTINC: legal = (o == `OAD_OP_COMPARE_BRANCH);
        `OAD_MODE_RELATIVE: legal = (o == `OAD_OP_COMPARE_BRANCH) || (o == `OAD_OP_NONE);
        default: legal = (o != `OAD_OP_STACK_ADJUST) || (m == `OAD_MODE_LITERAL);
      endcase
    end
  endfunction

  assign ea = calc_ea(mode, byte1, byte2, index_pair, stack_ptr);
  assign ea_plus1 = ea + `OAD_ONE16;
  assign mode_ok = legal(op, mode);

  // ****************************************
  // request decode
  // ****************************************
  wire in_idle = (state == ST_IDLE);
  wire in_exec = (state == ST_EXEC);
  // a start seen outside idle is dropped, so callers space requests two cycles apart
  wire take = in_idle && start;
  wire accept = take && mode_ok;
  wire refuse = take && !mode_ok;

  // ****************************************
  // operation decode, from the latched request
  // ****************************************
  wire is_adc = (op_q == `OAD_OP_ADD_CARRY);
  wire is_add = is_adc || (op_q == `OAD_OP_ADD);
  wire is_adjust = (op_q == `OAD_OP_STACK_ADJUST);
  wire is_load = (op_q == `OAD_OP_LOAD);
  wire is_literal = (mode_q == `OAD_MODE_LITERAL);
  wire post_inc = (mode_q == `OAD_MODE_IX_POSTINC) || (mode_q == `OAD_MODE_IX_OFS_POSTINC);

  // ****************************************
  // adder
  // ****************************************
  // literal mode takes the instruction byte, every other mode the byte at ea
  wire [7:0] operand = is_literal ? b1_q : mem_hi;
  wire carry_in = is_adc ? condition_flag_register[`OAD_FLAG_C] : 1'b0;
  // the low nibble is summed apart to get the carry into bit 4
  wire [4:0] low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, carry_in};
  wire [8:0] sum = {1'b0, acc} + {1'b0, operand} + {8'h00, carry_in};
  wire [7:0] result = sum[7:0];
  // overflow: like-signed operands give a result of the other sign
  wire ovf = (acc[7] == operand[7]) && (result[7] != acc[7]);
  wire half = low_sum[4];
  wire neg = result[7];
  wire zero = (result == 8'h00);
  wire carry_out = sum[8];

  // ****************************************
  // sign extension for stack adjust and branch offset
  // ****************************************
  wire [15:0] adj = {{8{b1_q[7]}}, b1_q};
  wire [15:0] rel = {{8{b1_q[7]}}, b1_q};

  // ****************************************
  // control
  // ****************************************
  always @* begin
    case (state)
      ST_IDLE: next_state = accept ? ST_EXEC : ST_IDLE;
      ST_EXEC: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // request fields are captured whenever a start is taken, legal or not;
  // a refused request never reaches exec, so its fields are harmless
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      op_q <= `OAD_OP_NONE;
      mode_q <= `OAD_MODE_LITERAL;
      b1_q <= 8'h00;
      pc_q <= 16'h0000;
    end else if (take) begin
      op_q <= op;
      mode_q <= mode;
      b1_q <= byte1;
      pc_q <= next_pc;
    end
  end

  // ****************************************
  // accumulator; memory bytes are sampled in the exec cycle,
  // so the caller presents them one cycle after start
  // ****************************************
  always @* begin
    next_acc = acc;
    if (in_exec) begin
      if (is_add) begin
        next_acc = result;
      end else if (is_load) begin
        next_acc = operand;
      end
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc <= `OAD_ACC_RESET;
    end else begin
      acc <= next_acc;
    end
  end

  // ****************************************
  // condition flags; the interrupt mask is never written here
  // ****************************************
  always @* begin
    next_flags = condition_flag_register;
    if (in_exec && is_add) begin
      next_flags[`OAD_FLAG_V] = ovf;
      next_flags[`OAD_FLAG_H] = half;
      next_flags[`OAD_FLAG_N] = neg;
      next_flags[`OAD_FLAG_Z] = zero;
      next_flags[`OAD_FLAG_C] = carry_out;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      condition_flag_register <= `OAD_FLAG_RESET;
    end else begin
      // unused positions are masked so they can never leave zero
      condition_flag_register <= next_flags & `OAD_FLAG_USED;
    end
  end

  // ****************************************
  // index pair; bumped after the operand fetch of a post-increment mode
  // ****************************************
  always @* begin
    next_index = index_pair;
    if (in_exec && post_inc) begin
      next_index = index_pair + `OAD_ONE16;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      index_pair <= `OAD_INDEX_RESET;
    end else begin
      index_pair <= next_index;
    end
  end

  // ****************************************
  // stack pointer; adjust wraps modulo 64k and leaves the flags alone
  // ****************************************
  always @* begin
    next_sp = stack_ptr;
    if (in_exec && is_adjust) begin
      next_sp = stack_ptr + adj;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stack_ptr <= `OAD_SP_RESET;
    end else begin
      stack_ptr <= next_sp;
    end
  end

  // ****************************************
  // assembled memory word, high byte from the operand address
  // ****************************************
  always @* begin
    next_word = word_data;
    if (in_exec) begin
      next_word = {mem_hi, mem_lo};
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      word_data <= 16'h0000;
    end else begin
      word_data <= next_word;
    end
  end

  // ****************************************
  // branch target, worked out on every exec whatever the op;
  // only a branch makes use of it
  // ****************************************
  always @* begin
    next_target = branch_target;
    if (in_exec) begin
      next_target = pc_q + rel;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      branch_target <= 16'h0000;
    end else begin
      branch_target <= next_target;
    end
  end

  // ****************************************
  // status pulses
  // ****************************************
  always @* begin
    next_done = in_exec;
    next_bad_mode = refuse;
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
      bad_mode <= 1'b0;
    end else begin
      done <= next_done;
      bad_mode <= next_bad_mode;
    end
  end

endmodule // oad_core

`default_nettype wire

/* File: oad_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module oad_mem (
  input wire [15:0] ea, // high byte address
  input wire [15:0] ea_plus1, // low byte address
  output wire [7:0] mem_hi, // byte at ea
  output wire [7:0] mem_lo // byte at ea_plus1
);
  // an address hash keeps neighbours distinct except 7fff/8000 and ffff/0000, so a byte swap shows
  assign mem_hi = ea[7:0] ^ ea[15:8] ^ 8'h5a;
  assign mem_lo = ea_plus1[7:0] ^ ea_plus1[15:8] ^ 8'h5a;
endmodule // oad_mem
`default_nettype wire

/* File: oad_regs.vh */
`ifndef OAD_REGS_VH
`define OAD_REGS_VH

// ****************************************
// flag register bit positions
// ****************************************
`define OAD_FLAG_V 7
`define OAD_FLAG_H 4
`define OAD_FLAG_I 3
`define OAD_FLAG_N 2
`define OAD_FLAG_Z 1
`define OAD_FLAG_C 0
`define OAD_FLAG_RESET 8'h08
`define OAD_FLAG_USED 8'h9f

// ****************************************
// addressing modes
// ****************************************
`define OAD_MODE_LITERAL 4'h0
`define OAD_MODE_DIRECT 4'h1
`define OAD_MODE_FULL 4'h2
`define OAD_MODE_INDEX 4'h3
`define OAD_MODE_IX_SHORT 4'h4
`define OAD_MODE_IX_LONG 4'h5
`define OAD_MODE_IX_POSTINC 4'h6
`define OAD_MODE_IX_OFS_POSTINC 4'h7
`define OAD_MODE_SP_SHORT 4'h8
`define OAD_MODE_SP_LONG 4'h9
`define OAD_MODE_RELATIVE 4'ha

// ****************************************
// operations
// ****************************************
`define OAD_OP_NONE 3'h0
`define OAD_OP_ADD_CARRY 3'h1
`define OAD_OP_ADD 3'h2
`define OAD_OP_STACK_ADJUST 3'h3
`define OAD_OP_COMPARE_BRANCH 3'h4
`define OAD_OP_MOVE 3'h5
`define OAD_OP_LOAD 3'h6

`define OAD_ACC_RESET 8'h00
`define OAD_INDEX_RESET 16'h0000
`define OAD_SP_RESET 16'h00ff
`define OAD_ONE16 16'h0001

`endif
